// ### core/pem_pkg.sv
// Package with register map, field layout, mode codes and carrier types for the port E control block.
package pem_pkg;

  // Register byte offsets on the APB window.
  localparam logic [7:0] PEM_DIR_OFFSET    = 8'h00;
  localparam logic [7:0] PEM_FUNC_OFFSET   = 8'h04;
  localparam logic [7:0] PEM_DATA_OFFSET   = 8'h08;
  localparam logic [7:0] PEM_STATUS_OFFSET = 8'h0C;

  // Field positions of the pin function select register.
  localparam int PEM_FREE_BIT = 7;
  localparam int PEM_PIPE_BIT = 5;
  localparam int PEM_BUS_CLOCK_OUT_BIT = 4;
  localparam int PEM_LSTR_BIT = 3;
  localparam int PEM_RW_BIT   = 2;

  // Implemented bit masks.
  localparam logic [7:0] PEM_DIR_MASK  = 8'hFC;
  localparam logic [7:0] PEM_FUNC_MASK = 8'hBC;
  localparam logic [7:0] PEM_ONCE_MASK = 8'hAC;
  localparam logic [7:0] PEM_BUS_CLOCK_OUT_MASK = 8'h10;
  localparam logic [7:0] PEM_IRQ_MASK  = 8'h03;

  // Reset values.
  localparam logic [7:0] PEM_DIR_RESET        = 8'h00;
  localparam logic [7:0] PEM_DATA_RESET       = 8'h00;
  localparam logic [7:0] PEM_FUNC_RST_SPECIAL = 8'h00;
  localparam logic [7:0] PEM_FUNC_RST_TEST    = 8'h2C;
  localparam logic [7:0] PEM_FUNC_RST_EMUL    = 8'hAC;
  localparam logic [7:0] PEM_FUNC_RST_NSINGLE = 8'h10;
  localparam logic [7:0] PEM_FUNC_RST_NEXP    = 8'h00;

  typedef enum logic [2:0] {
    PEM_MODE_SPECIAL_SINGLE = 3'b000,
    PEM_MODE_EMUL_NARROW    = 3'b001,
    PEM_MODE_SPECIAL_TEST   = 3'b010,
    PEM_MODE_EMUL_WIDE      = 3'b011,
    PEM_MODE_NORMAL_SINGLE  = 3'b100,
    PEM_MODE_NORMAL_NARROW  = 3'b101,
    PEM_MODE_PERIPHERAL     = 3'b110,
    PEM_MODE_NORMAL_WIDE    = 3'b111
  } pem_mode_t;

  typedef enum logic [1:0] {
    PEM_ST_IDLE   = 2'b00,
    PEM_ST_ACCESS = 2'b01,
    PEM_ST_EXT    = 2'b10
  } pem_state_t;

  // Bus control sources that may be routed onto port E pins.
  typedef struct packed {
    logic free_cycle;
    logic queue_status_hi;
    logic queue_status_lo;
    logic bus_clock;
    logic low_byte_strobe;
    logic rw;
  } pem_bus_ctrl_t;

  // Access forwarded to the external bus when a register is not on chip.
  typedef struct packed {
    logic        req;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } pem_ext_req_t;

endpackage

// ### core/pem_port_e_ctrl.sv
// Port E direction, function assignment and data latch with APB access and external pass-through.
// Function
// - GPIO pin drives out when direction bit set.
// - Interrupt-shared pins 1:0 never become outputs.
// - Pins 1:0 always read their pin level.
// - Data read: input pin level or latch.
// - Unmapped register accesses forwarded to external bus.
// - Expanded mode with emulate bit hides direction.
// - Bus function overrides the pin direction bit.
// - Normal single-chip reset: only clock-disable set.
// - Normal expanded reset: bus clock and free cycle enabled.
// - Test reset enables all bus controls, emulation reset all but free cycle.
// - Enables: once normal single, anytime special single, else not on chip.
// - Free-cycle enable clear drives free-cycle on pin7.
// - Free, pipe, rw inert in single/peripheral.
// - Pipe enable drives queue status pins 6:5.
// - Clock-disable zero outputs bus clock pin4.
// - Low strobe on pin3, tag sampled first.
// - Low strobe inert single, peripheral, normal narrow.
// - Read/write enable drives rw on pin2.
// - Emulate bit unmaps data and direction registers in expanded modes.
`timescale 1ns/1ps
`default_nettype none

module pem_port_e_ctrl (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire pem_pkg::pem_mode_t     mode_sel,
  input  wire logic                   emulate_port_select,
  input  wire logic                   clock_stretch_select,
  input  wire logic                   debug_tag_enable,
  input  wire logic                   ext_cycle_active,
  input  wire pem_pkg::pem_bus_ctrl_t bus_ctrl,
  input  wire logic [7:0]             pin_in,
  output logic [7:0]                  pin_out,
  output logic [7:0]                  pin_oe_n,
  output logic                        debug_tag_low,
  output pem_pkg::pem_ext_req_t       ext_req,
  input  wire logic                   ext_ack,
  input  wire logic [31:0]            ext_rdata
);

  function automatic logic is_single(input pem_pkg::pem_mode_t m);
    is_single = (m == pem_pkg::PEM_MODE_SPECIAL_SINGLE) || (m == pem_pkg::PEM_MODE_NORMAL_SINGLE);
  endfunction

  function automatic logic is_periph(input pem_pkg::pem_mode_t m);
    is_periph = (m == pem_pkg::PEM_MODE_PERIPHERAL);
  endfunction

  function automatic logic is_emul(input pem_pkg::pem_mode_t m);
    is_emul = (m == pem_pkg::PEM_MODE_EMUL_NARROW) || (m == pem_pkg::PEM_MODE_EMUL_WIDE);
  endfunction

  function automatic logic is_normal(input pem_pkg::pem_mode_t m);
    is_normal = (m == pem_pkg::PEM_MODE_NORMAL_SINGLE) || (m == pem_pkg::PEM_MODE_NORMAL_NARROW) ||
                (m == pem_pkg::PEM_MODE_NORMAL_WIDE);
  endfunction

  function automatic logic [7:0] func_reset_value(input pem_pkg::pem_mode_t m);
    case (m)
      pem_pkg::PEM_MODE_NORMAL_SINGLE: func_reset_value = pem_pkg::PEM_FUNC_RST_NSINGLE;
      pem_pkg::PEM_MODE_NORMAL_NARROW: func_reset_value = pem_pkg::PEM_FUNC_RST_NEXP;
      pem_pkg::PEM_MODE_NORMAL_WIDE:   func_reset_value = pem_pkg::PEM_FUNC_RST_NEXP;
      pem_pkg::PEM_MODE_SPECIAL_TEST:  func_reset_value = pem_pkg::PEM_FUNC_RST_TEST;
      pem_pkg::PEM_MODE_EMUL_NARROW:   func_reset_value = pem_pkg::PEM_FUNC_RST_EMUL;
      pem_pkg::PEM_MODE_EMUL_WIDE:     func_reset_value = pem_pkg::PEM_FUNC_RST_EMUL;
      default:                         func_reset_value = pem_pkg::PEM_FUNC_RST_SPECIAL;
    endcase
  endfunction

  pem_pkg::pem_state_t   state_reg;
  logic                  init_pending_reg;
  logic                  once_used_reg;
  logic [7:0]            dir_reg;
  logic [7:0]            func_reg;
  logic [7:0]            data_reg;
  logic [7:0]            pin_meta_reg;
  logic [7:0]            pin_sync_reg;
  logic                  bus_clock_out_prev_reg;
  logic [31:0]           prdata_reg;
  logic                  pready_reg;
  logic                  pslverr_reg;
  logic [7:0]            pin_out_reg;
  logic [7:0]            pin_oe_n_reg;
  logic                  debug_tag_low_reg;
  pem_pkg::pem_ext_req_t ext_req_reg;

  logic       single_chip;
  logic       bus_modes;
  logic       dir_mapped;
  logic       func_mapped;
  logic       hit_dir;
  logic       hit_func;
  logic       hit_data;
  logic       hit_status;
  logic       hit_ext;
  logic       setup;
  logic       complete;
  logic [7:0] func_wr_allow;
  logic [7:0] data_view;
  logic [7:0] pin_out_next;
  logic [7:0] pin_oe_next;
  logic       free_on;
  logic       pipe_on;
  logic       bus_clock_out_on;
  logic       lstr_on;
  logic       rw_on;
  logic       tag_phase;

  assign single_chip = is_single(mode_sel);
  assign bus_modes   = !single_chip && !is_periph(mode_sel);
  // Data and direction stay on chip in single-chip modes, leave it in peripheral mode or when emulated in expanded modes.
  assign dir_mapped  = single_chip || (bus_modes && !emulate_port_select);
  assign func_mapped = single_chip;

  assign setup      = psel && !penable && (state_reg == pem_pkg::PEM_ST_IDLE);
  assign complete   = psel && penable && pready_reg;
  assign hit_dir    = (paddr == pem_pkg::PEM_DIR_OFFSET);
  assign hit_func   = (paddr == pem_pkg::PEM_FUNC_OFFSET);
  assign hit_data   = (paddr == pem_pkg::PEM_DATA_OFFSET);
  assign hit_status = (paddr == pem_pkg::PEM_STATUS_OFFSET);
  assign hit_ext    = ((hit_dir || hit_data) && !dir_mapped) || (hit_func && !func_mapped);

  // Pins 1:0 and input pins show the synchronised level, output pins the latch.
  assign data_view = (data_reg & dir_reg & pem_pkg::PEM_DIR_MASK) |
                     (pin_sync_reg & ~(dir_reg & pem_pkg::PEM_DIR_MASK));

  always_comb begin
    if (is_emul(mode_sel)) begin
      func_wr_allow = 8'h00;
    end else if (is_normal(mode_sel)) begin
      func_wr_allow = pem_pkg::PEM_BUS_CLOCK_OUT_MASK |
                      (once_used_reg ? 8'h00 : pem_pkg::PEM_ONCE_MASK);
    end else begin
      func_wr_allow = pem_pkg::PEM_FUNC_MASK;
    end
  end

  assign free_on = bus_modes && !func_reg[pem_pkg::PEM_FREE_BIT];
  assign pipe_on = bus_modes && func_reg[pem_pkg::PEM_PIPE_BIT];
  assign bus_clock_out_on = !func_reg[pem_pkg::PEM_BUS_CLOCK_OUT_BIT];
  assign lstr_on = bus_modes && (mode_sel != pem_pkg::PEM_MODE_NORMAL_NARROW) &&
                   func_reg[pem_pkg::PEM_LSTR_BIT];
  assign rw_on   = bus_modes && func_reg[pem_pkg::PEM_RW_BIT];
  // While tagging, the strobe pin listens during the high half of the bus clock.
  assign tag_phase = lstr_on && debug_tag_enable && bus_ctrl.bus_clock;

  always_comb begin
    pin_out_next = data_reg & pem_pkg::PEM_DIR_MASK;
    pin_oe_next  = dir_reg & pem_pkg::PEM_DIR_MASK & ~pem_pkg::PEM_IRQ_MASK;
    if (free_on) begin
      pin_out_next[7] = bus_ctrl.free_cycle;
      pin_oe_next[7]  = 1'b1;
    end
    if (pipe_on) begin
      pin_out_next[6] = bus_ctrl.queue_status_hi;
      pin_out_next[5] = bus_ctrl.queue_status_lo;
      pin_oe_next[6]  = 1'b1;
      pin_oe_next[5]  = 1'b1;
    end
    if (bus_clock_out_on) begin
      // With stretching selected the clock only runs during external cycles.
      pin_out_next[4] = bus_ctrl.bus_clock && (!clock_stretch_select || ext_cycle_active);
      pin_oe_next[4]  = 1'b1;
    end
    if (lstr_on) begin
      pin_out_next[3] = bus_ctrl.low_byte_strobe;
      pin_oe_next[3]  = !tag_phase;
    end
    if (rw_on) begin
      pin_out_next[2] = bus_ctrl.rw;
      pin_oe_next[2]  = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= 8'h00;
      pin_sync_reg <= 8'h00;
    end else begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_reg  <= 8'h00;
      pin_oe_n_reg <= 8'hFF;
    end else begin
      pin_out_reg  <= pin_out_next;
      pin_oe_n_reg <= ~pin_oe_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_clock_out_prev_reg     <= 1'b0;
      debug_tag_low_reg <= 1'b0;
    end else begin
      bus_clock_out_prev_reg <= bus_ctrl.bus_clock;
      if (lstr_on && debug_tag_enable && bus_ctrl.bus_clock && !bus_clock_out_prev_reg) begin
        debug_tag_low_reg <= pin_sync_reg[3];
      end
    end
  end

  // The function register takes its mode-dependent value on the first edge after reset release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_pending_reg <= 1'b1;
      func_reg         <= pem_pkg::PEM_FUNC_RST_SPECIAL;
      once_used_reg    <= 1'b0;
    end else if (init_pending_reg) begin
      init_pending_reg <= 1'b0;
      func_reg         <= func_reset_value(mode_sel);
    end else if (complete && pwrite && hit_func && func_mapped) begin
      func_reg <= (func_reg & ~func_wr_allow) |
                  (pwdata[7:0] & func_wr_allow & pem_pkg::PEM_FUNC_MASK);
      if (is_normal(mode_sel)) begin
        once_used_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_reg  <= pem_pkg::PEM_DIR_RESET;
      data_reg <= pem_pkg::PEM_DATA_RESET;
    end else if (complete && pwrite && dir_mapped) begin
      if (hit_dir) begin
        dir_reg <= pwdata[7:0] & pem_pkg::PEM_DIR_MASK;
      end
      if (hit_data) begin
        data_reg <= pwdata[7:0] & pem_pkg::PEM_DIR_MASK;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= pem_pkg::PEM_ST_IDLE;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      ext_req_reg <= '0;
    end else begin
      case (state_reg)
        pem_pkg::PEM_ST_IDLE: begin
          if (setup && hit_ext) begin
            ext_req_reg.req   <= 1'b1;
            ext_req_reg.write <= pwrite;
            ext_req_reg.addr  <= paddr;
            ext_req_reg.wdata <= pwdata;
            state_reg         <= pem_pkg::PEM_ST_EXT;
          end else if (setup) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= !(hit_dir || hit_func || hit_data || hit_status);
            prdata_reg  <= 32'h0000_0000;
            if (!pwrite && hit_dir) begin
              prdata_reg[7:0] <= dir_reg & pem_pkg::PEM_DIR_MASK;
            end else if (!pwrite && hit_func) begin
              prdata_reg[7:0] <= func_reg & pem_pkg::PEM_FUNC_MASK;
            end else if (!pwrite && hit_data) begin
              prdata_reg[7:0] <= data_view;
            end else if (!pwrite && hit_status) begin
              prdata_reg[7:0] <= {1'b0, once_used_reg, func_mapped, dir_mapped,
                                  1'b0, mode_sel};
            end
            state_reg <= pem_pkg::PEM_ST_ACCESS;
          end
        end
        pem_pkg::PEM_ST_EXT: begin
          if (ext_ack) begin
            ext_req_reg.req <= 1'b0;
            prdata_reg      <= ext_req_reg.write ? 32'h0000_0000 : ext_rdata;
            pready_reg      <= 1'b1;
            pslverr_reg     <= 1'b0;
            state_reg       <= pem_pkg::PEM_ST_ACCESS;
          end
        end
        pem_pkg::PEM_ST_ACCESS: begin
          if (complete) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            state_reg   <= pem_pkg::PEM_ST_IDLE;
          end
        end
        default: begin
          state_reg <= pem_pkg::PEM_ST_IDLE;
        end
      endcase
    end
  end

  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign pin_out       = pin_out_reg;
  assign pin_oe_n      = pin_oe_n_reg;
  assign debug_tag_low = debug_tag_low_reg;
  assign ext_req       = ext_req_reg;

endmodule // pem_port_e_ctrl

`default_nettype wire

// ### sim/pem_port_e_monitor.sv
// Concurrent checks on the port E control block ports.
`timescale 1ns/1ps
`default_nettype none
module pem_port_e_monitor (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire pem_pkg::pem_mode_t     mode_sel,
  input wire logic                   debug_tag_enable,
  input wire pem_pkg::pem_bus_ctrl_t bus_ctrl,
  input wire logic [7:0]             pin_out,
  input wire logic [7:0]             pin_oe_n,
  input wire pem_pkg::pem_ext_req_t  ext_req,
  input wire logic                   ext_ack
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [1:0] age_reg;
  logic       single_m;
  logic       test_m;
  logic       settled;
  assign single_m = (mode_sel[1:0] == 2'h0);
  assign test_m   = (mode_sel == pem_pkg::PEM_MODE_SPECIAL_TEST);
  assign settled  = (age_reg == 2'h3);
  // Pins carry the mode reset value only a few edges after release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) age_reg <= 2'h0;
    else if (!settled) age_reg <= age_reg + 2'h1;
  end
  property p_irq_pins; pin_oe_n[1:0] == 2'h3; endproperty
  a_irq_pins: assert property (p_irq_pins) else $error("interrupt pin driven");
  property p_local; psel && !penable && single_m && paddr == pem_pkg::PEM_FUNC_OFFSET
    |=> pready && !pslverr && prdata[31:8] == 24'h00_0000; endproperty
  a_local: assert property (p_local) else $error("local read not answered");
  property p_bad; psel && !penable && single_m && paddr == 8'h10
    |=> pready && pslverr && prdata == 32'h0000_0000; endproperty
  a_bad: assert property (p_bad) else $error("unknown offset accepted");
  property p_periph; psel && !penable && mode_sel == pem_pkg::PEM_MODE_PERIPHERAL
    && paddr == pem_pkg::PEM_DIR_OFFSET |=> ext_req.req; endproperty
  a_periph: assert property (p_periph) else $error("direction not forwarded");
  property p_fwd; psel && !penable && mode_sel == pem_pkg::PEM_MODE_NORMAL_WIDE && paddr == pem_pkg::PEM_FUNC_OFFSET
    |=> ext_req.req && ext_req.addr == $past(paddr) && ext_req.write == $past(pwrite); endproperty
  a_fwd: assert property (p_fwd) else $error("forwarded fields wrong");
  property p_ack; ext_req.req && ext_ack |=> !ext_req.req && pready; endproperty
  a_ack: assert property (p_ack) else $error("external answer lost");
  property p_single; single_m |-> !ext_req.req; endproperty
  a_single: assert property (p_single) else $error("single chip access forwarded");
  property p_tpins; test_m && !debug_tag_enable && settled |=> pin_out[7:2] == $past(bus_ctrl); endproperty
  a_tpins: assert property (p_tpins) else $error("bus control pins wrong");
  property p_toe; test_m && !debug_tag_enable && settled |=> pin_oe_n == 8'h03; endproperty
  a_toe: assert property (p_toe) else $error("test mode enables wrong");
  property p_tag; test_m && debug_tag_enable && bus_ctrl.bus_clock && settled |=> pin_oe_n[3]; endproperty
  a_tag: assert property (p_tag) else $error("strobe pin not released");
  c_fwd: cover property (ext_req.req && ext_ack);
  c_err: cover property (pready && pslverr);
  c_tag: cover property (test_m && debug_tag_enable && settled);
endmodule // pem_port_e_monitor
bind pem_port_e_ctrl pem_port_e_monitor u_pem_port_e_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_sel(mode_sel),
  .debug_tag_enable(debug_tag_enable), .bus_ctrl(bus_ctrl), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .ext_req(ext_req), .ext_ack(ext_ack));
`default_nettype wire

// ### sim/pem_ext_bus_model.sv
// Behavioural external bus memory answering forwarded register accesses.
`timescale 1ns/1ps
`default_nettype none
module pem_ext_bus_model (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire pem_pkg::pem_ext_req_t ext_req,
  input  wire logic [1:0]            wait_cycles,
  output logic                       ext_ack,
  output logic [31:0]                ext_rdata
);
  logic [31:0] mem [64];
  logic [1:0]  cnt_reg;
  logic        done_reg;
  initial foreach (mem[i]) mem[i] = 32'h0000_0000;
  // Outside an answer the read bus toggles, so stale data never looks valid.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_ack   <= 1'b0;
      ext_rdata <= 32'h0000_0000;
      cnt_reg   <= 2'h0;
      done_reg  <= 1'b0;
    end else begin
      ext_ack   <= 1'b0;
      ext_rdata <= ~ext_rdata;
      if (!ext_req.req) begin
        cnt_reg  <= 2'h0;
        done_reg <= 1'b0;
      end else if (ext_ack) begin
        done_reg <= 1'b1;
      end else if (!done_reg && cnt_reg == wait_cycles) begin
        ext_ack   <= 1'b1;
        ext_rdata <= mem[ext_req.addr[7:2]];
        if (ext_req.write) mem[ext_req.addr[7:2]] <= ext_req.wdata;
      end else if (!done_reg) begin
        cnt_reg <= cnt_reg + 2'h1;
      end
    end
  end
endmodule // pem_ext_bus_model
`default_nettype wire

// ### sim/pem_port_e_ctrl_tb_top.sv
// Self-checking testbench for the port E control block.
`timescale 1ns/1ps
`default_nettype none
module pem_port_e_ctrl_tb_top;
  localparam logic [7:0] DIR  = pem_pkg::PEM_DIR_OFFSET;
  localparam logic [7:0] FUNC = pem_pkg::PEM_FUNC_OFFSET;
  localparam logic [7:0] DATA = pem_pkg::PEM_DATA_OFFSET;
  localparam logic [7:0] OE_TAB [8] = '{8'hEF, 8'h83, 8'h03, 8'h83, 8'hFF, 8'h6F, 8'hEF, 8'h6F};
  logic                   pclk = 1'b0;
  logic                   presetn = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [7:0]             paddr = 8'h00;
  logic [31:0]            pwdata = 32'h0000_0000;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  pem_pkg::pem_mode_t     mode_sel = pem_pkg::PEM_MODE_NORMAL_SINGLE;
  logic                   emu_sel = 1'b0;
  logic                   tag_en = 1'b0;
  pem_pkg::pem_bus_ctrl_t bus_ctrl = 6'h00;
  logic [7:0]             pin_in = 8'h00;
  logic [7:0]             pin_out;
  logic [7:0]             pin_oe_n;
  logic                   tag_low;
  pem_pkg::pem_ext_req_t  ext_req;
  logic                   ext_ack;
  logic [31:0]            ext_rdata;
  logic [1:0]             ext_wait = 2'h0;
  logic [7:0]             v;
  logic [33:0]            note_q [$];
  logic [33:0]            nt;
  int                     err_total = 0;
  int                     cmp_count = 0;
  int                     cyc = 0;
  pem_port_e_ctrl u_pem_port_e_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_sel(mode_sel), .emulate_port_select(emu_sel), .clock_stretch_select(1'b0),
    .debug_tag_enable(tag_en), .ext_cycle_active(1'b0), .bus_ctrl(bus_ctrl), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .debug_tag_low(tag_low), .ext_req(ext_req),
    .ext_ack(ext_ack), .ext_rdata(ext_rdata));
  pem_ext_bus_model u_pem_ext_bus_model (
    .pclk(pclk), .presetn(presetn), .ext_req(ext_req), .wait_cycles(ext_wait),
    .ext_ack(ext_ack), .ext_rdata(ext_rdata));
  always #4 pclk = ~pclk;
  task automatic finish_test();
    // A transfer that never completed leaves its note behind.
    if (note_q.size() != 0) err_total++;
    $display("errors=%0d compares=%0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp_bus(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t bus got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Notes hold {write, error, data}; writes check only the error flag.
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      if (note_q.size() == 0) begin
        err_total++;
      end else begin
        nt = note_q.pop_front();
        if (nt[33]) cmp_bus({pslverr, 32'h0000_0000}, {nt[32], 32'h0000_0000});
        else cmp_bus({pslverr, prdata}, nt[32:0]);
      end
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    note_q.push_back({w, e});
    ext_wait <= 2'($urandom);
    psel     <= 1'b1;
    pwrite   <= w;
    paddr    <= a;
    pwdata   <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) err_total++;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h00_0000, d}, 33'h0_0000_0000);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0000_0000, {25'h000_0000, e});
  endtask
  task automatic pins(input logic [7:0] eo, input logic [7:0] eout);
    repeat (4) @(posedge pclk);
    cmp_pin(pin_oe_n, eo);
    cmp_pin(pin_out & ~eo & 8'hFC, eout & ~eo & 8'hFC);
  endtask
  task automatic rst(input pem_pkg::pem_mode_t m, input logic e);
    presetn  <= 1'b0;
    mode_sel <= m;
    emu_sel  <= e;
    bus_ctrl <= 6'($urandom);
    pin_in   <= 8'($urandom);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  initial begin
    void'($urandom(32'hfffd7a86));
    for (int i = 0; i < 8; i++) begin
      rst(pem_pkg::pem_mode_t'(i[2:0]), 1'b1);
      rd(DIR, 8'h00);
      pins(OE_TAB[i], {bus_ctrl, 2'h0});
    end
    rst(pem_pkg::PEM_MODE_NORMAL_SINGLE, 1'b0);
    rd(FUNC, 8'h10);
    wr(DATA, 8'hA4);
    wr(DIR, 8'hFF);
    rd(DIR, 8'hFC);
    pins(8'h03, 8'hA4);
    wr(DIR, 8'h0C);
    rd(DATA, (pin_in & 8'hF3) | 8'h04);
    wr(FUNC, 8'hFF);
    rd(FUNC, 8'hBC);
    wr(FUNC, 8'h00);
    rd(FUNC, 8'hAC);
    pins(8'hE3, {3'h0, bus_ctrl.bus_clock, 4'h4});
    xfer(1'b0, 8'h10, 32'h0000_0000, 33'h1_0000_0000);
    rst(pem_pkg::PEM_MODE_SPECIAL_SINGLE, 1'b0);
    rd(FUNC, 8'h00);
    for (int k = 0; k < 3; k++) begin
      v = 8'($urandom);
      wr(FUNC, v);
      rd(FUNC, v & pem_pkg::PEM_FUNC_MASK);
    end
    rst(pem_pkg::PEM_MODE_NORMAL_WIDE, 1'b0);
    wr(FUNC, 8'h5A);
    rd(FUNC, 8'h5A);
    wr(DATA, 8'h00);
    wr(DIR, 8'h04);
    pins(8'h6B, {bus_ctrl.free_cycle, 2'h0, bus_ctrl.bus_clock, 4'h0});
    emu_sel <= 1'b1;
    wr(DIR, 8'h33);
    rd(DIR, 8'h33);
    emu_sel <= 1'b0;
    rd(DIR, 8'h04);
    tag_en <= 1'b1;
    rst(pem_pkg::PEM_MODE_SPECIAL_TEST, 1'b0);
    bus_ctrl.bus_clock <= 1'b0;
    @(posedge pclk);
    bus_ctrl.bus_clock <= 1'b1;
    @(posedge pclk);
    pins(8'h0B, {bus_ctrl, 2'h0});
    cmp_pin({7'h00, tag_low}, {7'h00, pin_in[3]});
    finish_test();
  end
endmodule // pem_port_e_ctrl_tb_top
`default_nettype wire
